// ---- rtl/arcl_defines.vh ----
// Behaviour
// - Remote control acts only after the remote pin; inhibit pin always acts.
// - Remote request pin low selects remote control; high or open stays internal.
// - Under remote control sink or source is chosen by comparing the voltage set value with the terminal voltage; else source.
// - Any alarm during remote control switches the DC terminal off, as in manual.
// - The alarms shown on the alarm outputs are selected by configuration.
// - Link, overvoltage, overcurrent, overpower alarms latch until inhibit low-pulse of 50 ms.
// - Supply-fail and overtemperature latch only when their after-alarm state is Off.
// - Safety overvoltage alarm ignores acknowledgment; only a power cycle clears it.
// - Safety overvoltage shows as supply-fail and overvoltage indications together.
// - First alarm output high on overtemperature or supply-fail alarm, else low.
// - Second alarm output high on overvoltage, overcurrent or overpower alarm.
// - Regulation status: output low in constant voltage, high in other regulation.
// - Terminal status: output low while DC terminal on, high while off.
// - Default polarity: inhibit low requests terminal off, high or open on.
// - Resistance set value is taken only while resistance mode is active.
// - Status output carries regulation or terminal state, chosen by configuration.
// - Acknowledgment through the inhibit pin is honoured only under remote control.
// - Under remote control terminal follows only the inhibit pin and alarms; polarity selectable.
`ifndef ARCL_DEFINES_VH
`define ARCL_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ARCL_OFS_CTRL       5'h00
`define ARCL_OFS_ALARM_EN   5'h04
`define ARCL_OFS_MANUAL     5'h08
`define ARCL_OFS_STATUS     5'h0C
`define ARCL_OFS_RSET       5'h10

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define ARCL_CTRL_INH_INV   0
`define ARCL_CTRL_STAT_SEL  1
`define ARCL_CTRL_PF_OFF    2
`define ARCL_CTRL_OT_OFF    3
`define ARCL_CTRL_ALLOW     4
`define ARCL_CTRL_RST       5'h10
`define ARCL_ALARM_EN_RST   5'h1F

// ----------------------------------------------------------------
// alarm vector positions
// ----------------------------------------------------------------
`define ARCL_AL_LSUP        0
`define ARCL_AL_OV          1
`define ARCL_AL_OC          2
`define ARCL_AL_OP          3
`define ARCL_AL_PF          4
`define ARCL_AL_OT          5
`define ARCL_AL_SOV         6

// alarm enable bits
`define ARCL_EN_OT          0
`define ARCL_EN_PF          1
`define ARCL_EN_OV          2
`define ARCL_EN_OC          3
`define ARCL_EN_OP          4

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ARCL_CLK_KHZ        50000
`define ARCL_ACK_LOW_MS     50
`define ARCL_ACK_LOW_CYC    22'd2500000

`define ARCL_RESP_OKAY      2'h0
`define ARCL_RESP_SLVERR    2'h2

`endif

// ---- rtl/arcl_sync.v ----
`timescale 1ns/1ns
`default_nettype none
module arcl_sync #(
    parameter WIDTH = 3
) (
    // clock and reset
    input  wire             aclk,
    input  wire             aresetn,
    // levels
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            // pins idle high (open), so reset to high
            always @(posedge aclk) begin
                if (!aresetn) begin
                    meta_r[i] <= 1'b1;
                    sync_r[i] <= 1'b1;
                end else begin
                    meta_r[i] <= async_in[i];
                    sync_r[i] <= meta_r[i];
                end
            end
        end
    endgenerate

    assign sync_out = sync_r;
endmodule // arcl_sync
`default_nettype wire

// ---- rtl/arcl_top.v ----
`timescale 1ns/1ns
`default_nettype none
`include "arcl_defines.vh"
module arcl_top #(
    parameter [21:0] ACK_LOW_CYC = `ARCL_ACK_LOW_CYC
) (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite write address
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // connector digital inputs
    input  wire        remote_request_n_pin,
    input  wire        resistance_mode_n_pin,
    input  wire        output_inhibit_pin,
    // connector digital outputs
    output reg         alarm1_out_r,
    output reg         alarm2_out_r,
    output reg         status_out_r,
    // sampled set values and terminal voltage
    input  wire [15:0] voltage_setpoint_in,
    input  wire [15:0] voltage_actual_in,
    input  wire [15:0] resistance_setpoint_in,
    // internal alarm detectors and regulator
    input  wire        link_supervision_alarm,
    input  wire        overvoltage_alarm,
    input  wire        overcurrent_alarm,
    input  wire        overpower_alarm,
    input  wire        supply_failure_alarm,
    input  wire        overtemperature_alarm,
    input  wire        safety_overvoltage_alarm,
    input  wire        constant_voltage_state,
    // control results
    output reg         dc_terminal_on_r,
    output reg         remote_active_r,
    output reg         resistance_mode_r,
    output reg         sink_mode_r,
    output reg  [15:0] resistance_setpoint_r
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    wire [2:0] pins_sync;

    arcl_sync #(
        .WIDTH (3)
    ) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in ({output_inhibit_pin, resistance_mode_n_pin, remote_request_n_pin}),
        .sync_out (pins_sync)
    );

    wire remote_n_s = pins_sync[0];
    wire rmode_n_s  = pins_sync[1];
    wire inhibit_s  = pins_sync[2];

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg  [4:0]  ctrl_r;
    reg  [4:0]  alarm_en_r;
    reg         manual_on_r;
    reg  [6:0]  alarm_lat_r;
    reg  [21:0] low_cnt_r;
    reg         inh_prev_r;
    reg         ack_r;

    wire inh_inv   = ctrl_r[`ARCL_CTRL_INH_INV];
    wire stat_sel  = ctrl_r[`ARCL_CTRL_STAT_SEL];
    wire pf_off    = ctrl_r[`ARCL_CTRL_PF_OFF];
    wire ot_off    = ctrl_r[`ARCL_CTRL_OT_OFF];
    wire allow_rem = ctrl_r[`ARCL_CTRL_ALLOW];

    // 1 = terminal on requested, after polarity
    wire inh_on = inhibit_s ^ inh_inv;

    // ----------------------------------------------------------------
    // axi4-lite write
    // ----------------------------------------------------------------
    reg  [4:0]  aw_addr_r;
    reg         aw_held_r;
    reg  [31:0] w_data_r;
    reg         w_strb0_r;
    reg         w_held_r;

    wire aw_take  = s_axi_awvalid & s_axi_awready;
    wire w_take   = s_axi_wvalid & s_axi_wready;
    wire wr_fire  = aw_held_r & w_held_r & ~s_axi_bvalid;
    wire wr_hit   = (aw_addr_r == `ARCL_OFS_CTRL) | (aw_addr_r == `ARCL_OFS_ALARM_EN) |
                    (aw_addr_r == `ARCL_OFS_MANUAL);
    wire wr_ctrl  = wr_fire & w_strb0_r & (aw_addr_r == `ARCL_OFS_CTRL);
    wire wr_en    = wr_fire & w_strb0_r & (aw_addr_r == `ARCL_OFS_ALARM_EN);
    wire wr_man   = wr_fire & w_strb0_r & (aw_addr_r == `ARCL_OFS_MANUAL);

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `ARCL_RESP_OKAY;
            aw_addr_r     <= 5'h00;
            aw_held_r     <= 1'b0;
            w_data_r      <= 32'h00000000;
            w_strb0_r     <= 1'b0;
            w_held_r      <= 1'b0;
        end else begin
            s_axi_awready <= ~aw_held_r & ~aw_take & ~(s_axi_bvalid & ~s_axi_bready);
            s_axi_wready  <= ~w_held_r & ~w_take & ~(s_axi_bvalid & ~s_axi_bready);
            if (aw_take) begin
                aw_addr_r <= (s_axi_awaddr[31:5] == 27'h0000000) ?
                             {s_axi_awaddr[4:2], 2'b00} : 5'h1C;
                aw_held_r <= 1'b1;
            end
            if (w_take) begin
                w_data_r  <= s_axi_wdata;
                w_strb0_r <= s_axi_wstrb[0];
                w_held_r  <= 1'b1;
            end
            if (wr_fire) begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `ARCL_RESP_OKAY : `ARCL_RESP_SLVERR;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // configuration
    // ----------------------------------------------------------------
    wire any_alarm = |alarm_lat_r;

    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r      <= `ARCL_CTRL_RST;
            alarm_en_r  <= `ARCL_ALARM_EN_RST;
            manual_on_r <= 1'b0;
        end else begin
            if (wr_ctrl)
                ctrl_r <= w_data_r[4:0];
            if (wr_en)
                alarm_en_r <= w_data_r[4:0];
            // manual request drops on alarm, inhibit lock or remote control; a set write wins
            if (wr_man)
                manual_on_r <= w_data_r[0];
            else if (any_alarm | ~inh_on | remote_active_r)
                manual_on_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // acknowledge pulse detector
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            low_cnt_r  <= 22'h000000;
            inh_prev_r <= 1'b1;
            ack_r      <= 1'b0;
        end else begin
            inh_prev_r <= inh_on;
            if (inh_on)
                low_cnt_r <= 22'h000000;
            else if (low_cnt_r < ACK_LOW_CYC)
                low_cnt_r <= low_cnt_r + 22'h000001;
            ack_r <= inh_on & ~inh_prev_r & (low_cnt_r >= ACK_LOW_CYC) &
                     remote_active_r;
        end
    end

    // ----------------------------------------------------------------
    // alarm latches
    // ----------------------------------------------------------------
    wire [6:0] alarm_ev = {safety_overvoltage_alarm, overtemperature_alarm,
                           supply_failure_alarm, overpower_alarm, overcurrent_alarm,
                           overvoltage_alarm, link_supervision_alarm};
    // bits that hold once set
    wire [6:0] alarm_hold = {1'b1, ot_off, pf_off, 4'hF};
    // bits that an acknowledge clears
    wire [6:0] alarm_ackable = {1'b0, 6'h3F};

    genvar gi;
    generate
        for (gi = 0; gi < 7; gi = gi + 1) begin : g_alarm
            always @(posedge aclk) begin
                if (!aresetn)
                    alarm_lat_r[gi] <= 1'b0;
                else
                    alarm_lat_r[gi] <= alarm_ev[gi] |
                        (alarm_lat_r[gi] & alarm_hold[gi] &
                         ~(ack_r & alarm_ackable[gi]));
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // control location and terminal
    // ----------------------------------------------------------------
    wire remote_nxt = ~remote_n_s & allow_rem;
    wire rmode_nxt  = remote_active_r & ~rmode_n_s;
    wire term_nxt   = remote_active_r ? (inh_on & ~any_alarm) :
                      (manual_on_r & inh_on & ~any_alarm);

    always @(posedge aclk) begin
        if (!aresetn) begin
            remote_active_r       <= 1'b0;
            resistance_mode_r     <= 1'b0;
            dc_terminal_on_r      <= 1'b0;
            sink_mode_r           <= 1'b0;
            resistance_setpoint_r <= 16'h0000;
        end else begin
            remote_active_r   <= remote_nxt;
            resistance_mode_r <= rmode_nxt;
            dc_terminal_on_r  <= term_nxt;
            // sink when the voltage set value sits below the terminal voltage
            sink_mode_r <= remote_active_r &
                           (voltage_setpoint_in < voltage_actual_in);
            if (resistance_mode_r)
                resistance_setpoint_r <= resistance_setpoint_in;
        end
    end

    // ----------------------------------------------------------------
    // connector outputs
    // ----------------------------------------------------------------
    wire sov    = alarm_lat_r[`ARCL_AL_SOV];
    wire pf_ind = (alarm_lat_r[`ARCL_AL_PF] | sov) & alarm_en_r[`ARCL_EN_PF];
    wire ot_ind = alarm_lat_r[`ARCL_AL_OT] & alarm_en_r[`ARCL_EN_OT];
    wire ov_ind = (alarm_lat_r[`ARCL_AL_OV] | sov) & alarm_en_r[`ARCL_EN_OV];
    wire oc_ind = alarm_lat_r[`ARCL_AL_OC] & alarm_en_r[`ARCL_EN_OC];
    wire op_ind = alarm_lat_r[`ARCL_AL_OP] & alarm_en_r[`ARCL_EN_OP];

    always @(posedge aclk) begin
        if (!aresetn) begin
            alarm1_out_r <= 1'b0;
            alarm2_out_r <= 1'b0;
            status_out_r <= 1'b1;
        end else begin
            alarm1_out_r <= ot_ind | pf_ind;
            alarm2_out_r <= ov_ind | oc_ind | op_ind;
            if (stat_sel)
                status_out_r <= ~dc_terminal_on_r;
            else
                status_out_r <= ~constant_voltage_state;
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite read
    // ----------------------------------------------------------------
    reg [31:0] rd_mux;
    reg        rd_hit;

    always @* begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b1;
        if (s_axi_araddr[31:5] != 27'h0000000) begin
            rd_hit = 1'b0;
        end else begin
            case ({s_axi_araddr[4:2], 2'b00})
                `ARCL_OFS_CTRL:     rd_mux = {27'h0000000, ctrl_r};
                `ARCL_OFS_ALARM_EN: rd_mux = {27'h0000000, alarm_en_r};
                `ARCL_OFS_MANUAL:   rd_mux = {31'h00000000, manual_on_r};
                `ARCL_OFS_STATUS:   rd_mux = {16'h0000, inh_on, alarm_lat_r, 3'h0,
                                              status_out_r, sink_mode_r, dc_terminal_on_r,
                                              resistance_mode_r, remote_active_r};
                `ARCL_OFS_RSET:     rd_mux = {16'h0000, resistance_setpoint_r};
                default:            rd_hit = 1'b0;
            endcase
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `ARCL_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_hit ? `ARCL_RESP_OKAY : `ARCL_RESP_SLVERR;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // arcl_top
`default_nettype wire

// ---- sim/arcl_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
module arcl_properties (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus handshakes
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    // connector and detectors
    input wire logic        remote_request_n_pin,
    input wire logic        output_inhibit_pin,
    input wire logic        overcurrent_alarm,
    input wire logic        safety_overvoltage_alarm,
    input wire logic        alarm1_out_r,
    input wire logic        alarm2_out_r,
    // control results
    input wire logic        dc_terminal_on_r,
    input wire logic        remote_active_r,
    input wire logic        resistance_mode_r,
    input wire logic        sink_mode_r,
    input wire logic [15:0] resistance_setpoint_in,
    input wire logic [15:0] resistance_setpoint_r
);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_remote_select: assert property (remote_active_r |->
        !$past(remote_request_n_pin, 3) || !$past(remote_request_n_pin, 4))
        else $error("remote active without low request pin");
    a_rset_hold: assert property (!resistance_mode_r |=> $stable(resistance_setpoint_r))
        else $error("resistance set value moved outside resistance mode");
    a_rset_follow: assert property (resistance_mode_r |=>
        resistance_setpoint_r == $past(resistance_setpoint_in))
        else $error("resistance set value not taken");
    a_sink_remote: assert property (sink_mode_r |-> remote_active_r || $past(remote_active_r))
        else $error("sink mode outside remote control");
    a_term_inhibit: assert property (dc_terminal_on_r |->
        $past(output_inhibit_pin, 3) || $past(output_inhibit_pin, 4))
        else $error("terminal on while inhibit low");
    a_alarm_off: assert property (overcurrent_alarm |-> ##[1:4] !dc_terminal_on_r)
        else $error("terminal stayed on after alarm");
    a_safety_both: assert property (safety_overvoltage_alarm |->
        ##[1:4] (alarm1_out_r && alarm2_out_r))
        else $error("safety overvoltage not on both alarm outputs");
    a_wr_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read data missing");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
endmodule // arcl_properties
`default_nettype wire

// ---- sim/arcl_ctrl_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module arcl_ctrl_model (
    // clock
    input wire logic       aclk,
    // bench requests
    input wire logic       want_remote,
    input wire logic       want_rmode,
    input wire logic       ack_go,
    input wire logic [7:0] ack_len,
    // connector pins
    output logic           remote_request_n_pin,
    output logic           resistance_mode_n_pin,
    output logic           output_inhibit_pin
);
    logic       rem_r = 1'b1;
    logic       rmd_r = 1'b1;
    logic [7:0] low_r = 8'h00;
    // never looks at device outputs, so start-phase levels do not matter
    always @(posedge aclk) begin
        rem_r <= !want_remote;
        rmd_r <= !want_rmode;
        if (ack_go && low_r == 8'h00)
            low_r <= ack_len;
        else if (low_r != 8'h00)
            low_r <= low_r - 8'h01;
    end
    assign remote_request_n_pin  = rem_r;
    assign resistance_mode_n_pin = rmd_r;
    assign output_inhibit_pin    = (low_r == 8'h00);
endmodule // arcl_ctrl_model
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "arcl_defines.vh"
module tb;
    logic        aclk;
    logic        aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [15:0] voltage_setpoint_in = 16'h0100, voltage_actual_in = 16'h0080;
    logic [15:0] resistance_setpoint_in = 16'h1234, resistance_setpoint_r;
    logic        link_supervision_alarm = 0, overvoltage_alarm = 0, overcurrent_alarm = 0;
    logic        overpower_alarm = 0, supply_failure_alarm = 0, overtemperature_alarm = 0;
    logic        safety_overvoltage_alarm = 0, constant_voltage_state = 1;
    logic        remote_request_n_pin, resistance_mode_n_pin, output_inhibit_pin;
    logic        alarm1_out_r, alarm2_out_r, status_out_r, dc_terminal_on_r;
    logic        remote_active_r, resistance_mode_r, sink_mode_r;
    logic        want_remote = 0, want_rmode = 0, ack_go = 0;
    logic [7:0]  ack_len = 8'h00;
    int          fail_count = 0;
    int          num_checks = 0;

    arcl_top #(.ACK_LOW_CYC(22'd20)) arcl_top_i (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .remote_request_n_pin, .resistance_mode_n_pin, .output_inhibit_pin,
        .alarm1_out_r, .alarm2_out_r, .status_out_r, .voltage_setpoint_in,
        .voltage_actual_in, .resistance_setpoint_in, .link_supervision_alarm,
        .overvoltage_alarm, .overcurrent_alarm, .overpower_alarm, .supply_failure_alarm,
        .overtemperature_alarm, .safety_overvoltage_alarm, .constant_voltage_state,
        .dc_terminal_on_r, .remote_active_r, .resistance_mode_r, .sink_mode_r,
        .resistance_setpoint_r);
    arcl_ctrl_model arcl_ctrl_model_i (.aclk, .want_remote, .want_rmode, .ack_go, .ack_len,
        .remote_request_n_pin, .resistance_mode_n_pin, .output_inhibit_pin);
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task results;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40 && !s_axi_bvalid; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        if (n == 40)
            chk("write timeout", 0, 1);
        if (n == 40)
            results();
        s_axi_bready <= 1'b0;
        chk("bresp", s_axi_bresp, er);
    endtask
    task rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40 && !s_axi_rvalid; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        if (n == 40)
            chk("read timeout", 0, 1);
        if (n == 40)
            results();
        s_axi_rready <= 1'b0;
        chk("rdata", s_axi_rdata, ed);
        chk("rresp", s_axi_rresp, er);
    endtask
    task pulse(input logic [7:0] n);
        @(posedge aclk);
        ack_len <= n;
        ack_go <= 1'b1;
        @(posedge aclk);
        ack_go <= 1'b0;
        cyc(n / 2 + 4);
        chk("terminal in pulse", dc_terminal_on_r, 0);
        cyc(n);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_reset;
        cyc(1);
        chk("status cv", status_out_r, 0);
        chk("alarms idle", {alarm1_out_r, alarm2_out_r, remote_active_r}, 0);
        rd(`ARCL_OFS_CTRL, `ARCL_CTRL_RST, `ARCL_RESP_OKAY);
        rd(`ARCL_OFS_ALARM_EN, `ARCL_ALARM_EN_RST, `ARCL_RESP_OKAY);
        rd(`ARCL_OFS_MANUAL, 0, `ARCL_RESP_OKAY);
        rd(32'h1C, 0, `ARCL_RESP_SLVERR);
        wr(`ARCL_OFS_STATUS, 1, `ARCL_RESP_SLVERR);
    endtask
    task t_remote;
        want_remote <= 1'b1;
        cyc(8);
        chk("remote", remote_active_r, 1);
        chk("terminal", dc_terminal_on_r, 1);
        chk("source", sink_mode_r, 0);
        chk("status cv", status_out_r, 0);
        voltage_setpoint_in <= 16'h0040;
        constant_voltage_state <= 1'b0;
        cyc(4);
        chk("sink", sink_mode_r, 1);
        chk("status cc", status_out_r, 1);
        want_rmode <= 1'b1;
        cyc(8);
        chk("rmode on", resistance_mode_r, 1);
        chk("rset taken", resistance_setpoint_r, 16'h1234);
        want_rmode <= 1'b0;
        cyc(8);
        chk("rmode off", resistance_mode_r, 0);
        resistance_setpoint_in <= 16'h4321;
        wr(`ARCL_OFS_CTRL, 32'h12, `ARCL_RESP_OKAY);
        cyc(3);
        chk("status term on", status_out_r, 0);
        chk("rset held", resistance_setpoint_r, 16'h1234);
    endtask
    task t_latch;
        overcurrent_alarm <= 1'b1;
        cyc(1);
        overcurrent_alarm <= 1'b0;
        cyc(4);
        chk("terminal alarm", dc_terminal_on_r, 0);
        chk("alarm2", alarm2_out_r, 1);
        chk("status term off", status_out_r, 1);
        want_remote <= 1'b0;
        cyc(8);
        chk("remote off", remote_active_r, 0);
        pulse(8'd30);
        chk("ack local", alarm2_out_r, 1);
        want_remote <= 1'b1;
        cyc(8);
        pulse(8'd15);
        chk("ack short", alarm2_out_r, 1);
        pulse(8'd25);
        chk("ack done", alarm2_out_r, 0);
        chk("terminal back", dc_terminal_on_r, 1);
    endtask
    task t_first;
        overtemperature_alarm <= 1'b1;
        cyc(5);
        chk("alarm1", alarm1_out_r, 1);
        chk("alarm2 quiet", alarm2_out_r, 0);
        overtemperature_alarm <= 1'b0;
        cyc(5);
        chk("alarm1 free", alarm1_out_r, 0);
        chk("terminal free", dc_terminal_on_r, 1);
        wr(`ARCL_OFS_ALARM_EN, 32'h1E, `ARCL_RESP_OKAY);
        overtemperature_alarm <= 1'b1;
        cyc(5);
        chk("alarm1 masked", alarm1_out_r, 0);
        overtemperature_alarm <= 1'b0;
        wr(`ARCL_OFS_ALARM_EN, 32'h1F, `ARCL_RESP_OKAY);
        wr(`ARCL_OFS_CTRL, 32'h1A, `ARCL_RESP_OKAY);
        overtemperature_alarm <= 1'b1;
        cyc(1);
        overtemperature_alarm <= 1'b0;
        cyc(5);
        chk("alarm1 latched", alarm1_out_r, 1);
        pulse(8'd25);
        chk("alarm1 acked", alarm1_out_r, 0);
    endtask
    task t_safety;
        safety_overvoltage_alarm <= 1'b1;
        cyc(1);
        safety_overvoltage_alarm <= 1'b0;
        cyc(5);
        chk("safety both", {alarm1_out_r, alarm2_out_r}, 2'b11);
        pulse(8'd25);
        chk("safety kept", {alarm1_out_r, alarm2_out_r}, 2'b11);
    endtask

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_remote();
        t_latch();
        t_first();
        t_safety();
        results();
    end
endmodule // tb
bind arcl_top arcl_properties arcl_properties_i (.*);
`default_nettype wire
